/* File: logic/awc_window_comparator.sv */
/*
 * window comparator beside the 10-bit converter result register. holds
 * the formatted result, the two limit words and the control register,
 * and sets a sticky match flag when a new result falls inside or outside
 * the window. assumes the converter logic runs on the same clock and
 * gives a one-cycle done pulse with the raw code and its input mode.
 */
// Notes on behaviour
// [RQ1] compare each new result, no processor help
// [RQ2] two writable limit pairs, high and low
// [RQ3] limit ordering alone picks inside or outside
// [RQ4] upper below lower: flag strictly between them
// [RQ5] upper above lower: flag strictly outside them
// [RQ6] single-ended: unsigned comparison of all words
// [RQ7] differential: signed comparison, 0xffff is minus one
// [RQ8] differential outside: below minus one, above 64
// [RQ9] flag readable for polling by software
// [RQ10] lower-limit low byte resets zero, fully writable
// [RQ11] flag sticky until cleared, control bit 1
// [RQ12] right justify sign-extends bit 9 when differential; left fills
// [RQ13] compare justified word once per conversion
`timescale 1ns/1ps

module awc_window_comparator (
    input  wire logic        SYS_CLK_IN,
    input  wire logic        RST_B_IN,
    input  wire logic [7:0]  SFR_ADDR_IN,
    input  wire logic [7:0]  SFR_WDATA_IN,
    input  wire logic        SFR_WR_IN,
    input  wire logic        SFR_RD_IN,
    input  wire logic        CONV_DONE_IN,
    input  wire logic [9:0]  CONV_DATA_IN,
    input  wire logic        DIFF_MODE_IN,
    output logic      [7:0]  SFR_RDATA_OUT,
    output logic             MATCH_FLAG_OUT,
    output logic             LEFT_JUSTIFY_OUT
);

    // register state
    awc_pkg::awc_limits_t limits;
    logic [15:0]          result_word;
    logic [7:0]           control_other;
    logic                 window_match_flag;
    logic                 left_justify_select;

    // comparison path
    logic [15:0]          formatted;
    logic                 above_upper;
    logic                 below_lower;
    logic                 inside_mode;
    logic                 match_now;
    logic                 flag_write;

    // address hit on the register port
    function automatic logic hit(input logic [7:0] addr,
                                 input logic [7:0] ofs);
        hit = (addr == ofs);
    endfunction

    // strict less-than, signed or unsigned
    function automatic logic less(input logic [15:0] a,
                                  input logic [15:0] b,
                                  input logic        signed_cmp);
        if (signed_cmp)
        begin
            less = ($signed(a) < $signed(b));
        end
        else
        begin
            less = (a < b);
        end
    endfunction

    // justify the raw code into the 16-bit result word
    // [RQ12] sign extension or left fill
    always_comb
    begin
        if (left_justify_select)
        begin
            formatted = {CONV_DATA_IN, {awc_pkg::PAD_W{1'b0}}};
        end
        else if (DIFF_MODE_IN)
        begin
            formatted = {{awc_pkg::PAD_W{CONV_DATA_IN[9]}}, CONV_DATA_IN};
        end
        else
        begin
            formatted = {{awc_pkg::PAD_W{1'b0}}, CONV_DATA_IN};
        end
    end

    // window decision on the formatted word
    // [RQ3] ordering of limits picks the mode
    // [RQ6] unsigned when single-ended
    // [RQ7] signed when differential
    always_comb
    begin
        above_upper = less(limits.upper, formatted, DIFF_MODE_IN);
        below_lower = less(formatted, limits.lower, DIFF_MODE_IN);
        inside_mode = less(limits.upper, limits.lower, DIFF_MODE_IN);
        // [RQ4] inside window
        // [RQ5] outside window, also [RQ8] signed
        if (inside_mode)
        begin
            match_now = above_upper && below_lower;
        end
        else
        begin
            match_now = above_upper || below_lower;
        end
    end

    assign flag_write = SFR_WR_IN && hit(SFR_ADDR_IN, awc_pkg::OFS_CONTROL);

    // limit registers written by software
    // [RQ2] limit pairs
    // [RQ10] lower low byte reset and write
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            limits <= awc_pkg::RST_LIMITS;
        end
        else if (SFR_WR_IN)
        begin
            if (hit(SFR_ADDR_IN, awc_pkg::OFS_UPPER_LOW))
                limits.upper[7:0] <= SFR_WDATA_IN;
            if (hit(SFR_ADDR_IN, awc_pkg::OFS_UPPER_HIGH))
                limits.upper[15:8] <= SFR_WDATA_IN;
            if (hit(SFR_ADDR_IN, awc_pkg::OFS_LOWER_LOW))
                limits.lower[7:0] <= SFR_WDATA_IN;
            if (hit(SFR_ADDR_IN, awc_pkg::OFS_LOWER_HIGH))
                limits.lower[15:8] <= SFR_WDATA_IN;
        end
    end

    // control register, other bits plain storage
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            control_other       <= awc_pkg::RST_BYTE;
            left_justify_select <= 1'b0;
        end
        else if (flag_write)
        begin
            control_other       <= SFR_WDATA_IN;
            left_justify_select <= SFR_WDATA_IN[awc_pkg::BIT_LEFT_JUSTIFY];
        end
    end

    // result word captured on each conversion
    // [RQ13] once per completed conversion
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            result_word <= awc_pkg::RST_WORD;
        end
        else if (CONV_DONE_IN)
        begin
            result_word <= formatted;
        end
    end

    // sticky match flag; a new match beats a clearing write
    // [RQ1] hardware sets without software
    // [RQ11] sticky until software clears
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            window_match_flag <= 1'b0;
        end
        else if (CONV_DONE_IN && match_now)
        begin
            window_match_flag <= 1'b1;
        end
        else if (flag_write)
        begin
            window_match_flag <= SFR_WDATA_IN[awc_pkg::BIT_MATCH_FLAG];
        end
    end

    // registered read port, unmapped reads give zero
    // [RQ9] flag readable for polling
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            SFR_RDATA_OUT <= awc_pkg::RST_BYTE;
        end
        else if (SFR_RD_IN)
        begin
            SFR_RDATA_OUT <= awc_pkg::READ_UNMAPPED;
            if (hit(SFR_ADDR_IN, awc_pkg::OFS_RESULT_LOW))
                SFR_RDATA_OUT <= result_word[7:0];
            if (hit(SFR_ADDR_IN, awc_pkg::OFS_RESULT_HIGH))
                SFR_RDATA_OUT <= result_word[15:8];
            if (hit(SFR_ADDR_IN, awc_pkg::OFS_UPPER_LOW))
                SFR_RDATA_OUT <= limits.upper[7:0];
            if (hit(SFR_ADDR_IN, awc_pkg::OFS_UPPER_HIGH))
                SFR_RDATA_OUT <= limits.upper[15:8];
            if (hit(SFR_ADDR_IN, awc_pkg::OFS_LOWER_LOW))
                SFR_RDATA_OUT <= limits.lower[7:0];
            if (hit(SFR_ADDR_IN, awc_pkg::OFS_LOWER_HIGH))
                SFR_RDATA_OUT <= limits.lower[15:8];
            if (hit(SFR_ADDR_IN, awc_pkg::OFS_CONTROL))
                SFR_RDATA_OUT <= {control_other[7:2], window_match_flag,
                                  left_justify_select};
        end
        else
        begin
            SFR_RDATA_OUT <= awc_pkg::RST_BYTE;
        end
    end

    // status outputs registered, one cycle behind their flops
    always_ff @(posedge SYS_CLK_IN)
    begin
        if (!RST_B_IN)
        begin
            MATCH_FLAG_OUT   <= 1'b0;
            LEFT_JUSTIFY_OUT <= 1'b0;
        end
        else
        begin
            MATCH_FLAG_OUT   <= next_flag_out();
            LEFT_JUSTIFY_OUT <= left_justify_select;
        end
    end

    // flag output mirrors the flag one cycle later
    function automatic logic next_flag_out();
        next_flag_out = window_match_flag;
    endfunction

    // independent reference for single-ended right-justified words
    logic [15:0] ref_word;
    assign ref_word = {6'h00, CONV_DATA_IN};

    sequence conv_match_s;
        CONV_DONE_IN && match_now;
    endsequence

    sequence flag_clear_s;
        flag_write && !SFR_WDATA_IN[1] && !(CONV_DONE_IN && match_now);
    endsequence

    sequence se_right_s;
        CONV_DONE_IN && !DIFF_MODE_IN && !left_justify_select;
    endsequence

    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (!RST_B_IN);

    flag_set_a: assert property ( // [RQ1]
        conv_match_s |=> window_match_flag ##1 MATCH_FLAG_OUT)
        else $error("match did not set the flag");

    flag_sticky_a: assert property ( // [RQ11]
        window_match_flag && !flag_write |=> window_match_flag)
        else $error("flag dropped without a clear");

    flag_clear_a: assert property ( // [RQ11]
        flag_clear_s |=> !window_match_flag)
        else $error("clearing write ignored");

    inside_window_a: assert property ( // [RQ4]
        (se_right_s and ((limits.upper < limits.lower)
        && !window_match_flag && !flag_write)) |=> window_match_flag ==
        (($past(ref_word) > $past(limits.upper))
         && ($past(ref_word) < $past(limits.lower))))
        else $error("inside window decision wrong");

    outside_window_a: assert property ( // [RQ5]
        (se_right_s and ((limits.upper > limits.lower)
        && !window_match_flag && !flag_write)) |=> window_match_flag ==
        (($past(ref_word) > $past(limits.upper))
         || ($past(ref_word) < $past(limits.lower))))
        else $error("outside window decision wrong");

    diff_signed_a: assert property ( // [RQ8]
        CONV_DONE_IN && DIFF_MODE_IN && !left_justify_select
        && limits.upper == 16'h0040 && limits.lower == 16'hffff
        && CONV_DATA_IN == 10'h3fe |-> match_now)
        else $error("signed outside compare wrong");

    unsigned_cmp_a: assert property ( // [RQ6]
        (se_right_s and (limits.upper == 16'h0040
        && limits.lower == 16'h0080 && CONV_DATA_IN == 10'h3ff))
        |-> !match_now)
        else $error("single-ended compare not unsigned");

    right_sign_a: assert property ( // [RQ12]
        CONV_DONE_IN && DIFF_MODE_IN && !left_justify_select
        |=> result_word[15:10] == {6{result_word[9]}})
        else $error("right justify sign extension wrong");

    left_fill_a: assert property ( // [RQ12]
        CONV_DONE_IN && left_justify_select
        |=> result_word == {$past(CONV_DATA_IN), 6'h00})
        else $error("left justified word wrong");

    lower_low_a: assert property ( // [RQ10]
        SFR_WR_IN && SFR_ADDR_IN == 8'hc6
        |=> limits.lower[7:0] == $past(SFR_WDATA_IN))
        else $error("lower limit low byte not written");

    poll_read_a: assert property ( // [RQ9]
        SFR_RD_IN && SFR_ADDR_IN == 8'he8
        |=> SFR_RDATA_OUT[1] == $past(window_match_flag))
        else $error("flag not readable");

endmodule // awc_window_comparator

/* File: logic/awc_pkg.sv */
/*
 * constants and types for the converter window comparator: register
 * offsets on the special-function-register port, control bit positions,
 * reset values and the packed carrier for the two limit words.
 * assumes a byte-wide register port and a 10-bit converter result.
 */
package awc_pkg;

    // converter and word widths
    localparam int unsigned CONV_W     = 10;
    localparam int unsigned WORD_W     = 16;
    localparam int unsigned BYTE_W     = 8;
    localparam int unsigned PAD_W      = WORD_W - CONV_W;

    // register offsets on the register port
    localparam logic [7:0] OFS_RESULT_LOW  = 8'hbe;
    localparam logic [7:0] OFS_RESULT_HIGH = 8'hbf;
    localparam logic [7:0] OFS_UPPER_LOW   = 8'hc4;
    localparam logic [7:0] OFS_UPPER_HIGH  = 8'hc5;
    localparam logic [7:0] OFS_LOWER_LOW   = 8'hc6;
    localparam logic [7:0] OFS_LOWER_HIGH  = 8'hc7;
    localparam logic [7:0] OFS_CONTROL     = 8'he8;

    // control register bit positions
    localparam int unsigned BIT_LEFT_JUSTIFY = 0;
    localparam int unsigned BIT_MATCH_FLAG   = 1;

    // reset values
    localparam logic [7:0]  RST_BYTE    = 8'h00;
    localparam logic [15:0] RST_WORD    = 16'h0000;
    localparam logic [7:0]  READ_UNMAPPED = 8'h00;

    // the two comparison limits as one carrier
    typedef struct packed {
        logic [15:0] upper;   // greater-than limit
        logic [15:0] lower;   // less-than limit
    } awc_limits_t;

    localparam awc_limits_t RST_LIMITS = '{upper: 16'h0000,
                                           lower: 16'h0000};

endpackage

/* File: testbench/awc_conv_model.sv */
/*
 * converter-side model: on a request it returns the code and input mode
 * with a one-cycle done pulse after a short latency.
 * assumes the comparator's clock and synchronous active-low reset.
 */
`timescale 1ns/1ps

module awc_conv_model #(
    parameter int LAT = 3
) (
    input  wire logic       clk_in,
    input  wire logic       rst_b_in,
    input  wire logic       req_in,
    input  wire logic [9:0] code_in,
    input  wire logic       diff_in,
    output logic            done_out,
    output logic      [9:0] data_out,
    output logic            diff_out
);
    logic [9:0] code;
    logic       diff;
    logic [3:0] cnt;

    // latency count, then one done pulse; idle lines toggle every cycle
    // one pulse per conversion
    always_ff @(posedge clk_in)
    begin
        if (!rst_b_in)
        begin
            cnt      <= 4'h0;
            done_out <= 1'b0;
            data_out <= 10'h155;
            diff_out <= 1'b0;
        end
        else
        begin
            done_out <= 1'b0;
            data_out <= ~data_out;
            diff_out <= ~diff_out;
            if (req_in)
            begin
                code <= code_in;
                diff <= diff_in;
                cnt  <= 4'(LAT);
            end
            else if (cnt != 4'h0)
                cnt <= cnt - 4'h1;
            if (cnt == 4'h1)
            begin
                done_out <= 1'b1;
                data_out <= code;
                diff_out <= diff;
            end
        end
    end
endmodule // awc_conv_model

/* File: testbench/test_adc_window_comparator.sv */
/*
 * self-checking bench for the window comparator: register access,
 * documented corner windows and seeded random conversions.
 * assumes awc_pkg and the converter model are compiled first.
 */
`timescale 1ns/1ps

module test_adc_window_comparator;
    logic        clk, rst_b, wr, rd, req, diff, done, cdiff, mflag, ljo;
    logic [7:0]  addr, wdata, rdata;
    logic [9:0]  code, cdata;
    logic [31:0] r;
    int          fail_count, n_tests, cyc, seed;
    logic [7:0]  ofs [7] = '{awc_pkg::OFS_RESULT_LOW, awc_pkg::OFS_RESULT_HIGH,
        awc_pkg::OFS_UPPER_LOW, awc_pkg::OFS_UPPER_HIGH,
        awc_pkg::OFS_LOWER_LOW, awc_pkg::OFS_LOWER_HIGH, awc_pkg::OFS_CONTROL};

    awc_window_comparator awc_window_comparator_inst (.SYS_CLK_IN(clk),
        .RST_B_IN(rst_b), .SFR_ADDR_IN(addr), .SFR_WDATA_IN(wdata),
        .SFR_WR_IN(wr), .SFR_RD_IN(rd), .CONV_DONE_IN(done),
        .CONV_DATA_IN(cdata), .DIFF_MODE_IN(cdiff), .SFR_RDATA_OUT(rdata),
        .MATCH_FLAG_OUT(mflag), .LEFT_JUSTIFY_OUT(ljo));
    awc_conv_model awc_conv_model_inst (.clk_in(clk), .rst_b_in(rst_b),
        .req_in(req), .code_in(code), .diff_in(diff), .done_out(done),
        .data_out(cdata), .diff_out(cdiff));

    // expected justified word
    function automatic logic [15:0] fmt(logic [9:0] c, logic d, logic lj);
        if (lj)
            return {c, 6'h00};
        return d ? {{6{c[9]}}, c} : {6'h00, c};
    endfunction

    // expected match: limit order picks inside or outside
    function automatic logic hit(logic [15:0] w, up, lo, logic d);
        logic ul, gu, ll;
        ul = d ? ($signed(up) < $signed(lo)) : (up < lo);
        gu = d ? ($signed(w) > $signed(up)) : (w > up);
        ll = d ? ($signed(w) < $signed(lo)) : (w < lo);
        return ul ? (gu && ll) : (gu || ll);
    endfunction

    task automatic close_out();
        if (fail_count == 0 && n_tests > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(string nm, logic [15:0] seen, logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
    endtask

    task automatic rd_chk(string nm, logic [7:0] a, logic [7:0] e);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        check(nm, 16'(rdata), 16'(e));
    endtask

    task automatic conv(logic [9:0] c, logic d);
        int i;
        @(posedge clk);
        req  <= 1'b1;
        code <= c;
        diff <= d;
        @(posedge clk);
        req  <= 1'b0;
        for (i = 0; i < 20 && done !== 1'b1; i++)
        begin
            @(posedge clk);
            #1;
        end
        check("done", 16'(done), 16'h0001);
        repeat (2) @(posedge clk);
        #1;
    endtask

    task automatic trial(logic [15:0] up, lo, logic [9:0] c, logic d, lj);
        logic [15:0] w;
        logic        e;
        w = fmt(c, d, lj);
        e = hit(w, up, lo, d);
        wr_reg(awc_pkg::OFS_UPPER_HIGH, up[15:8]);
        wr_reg(awc_pkg::OFS_UPPER_LOW, up[7:0]);
        wr_reg(awc_pkg::OFS_LOWER_HIGH, lo[15:8]);
        wr_reg(awc_pkg::OFS_LOWER_LOW, lo[7:0]);
        wr_reg(awc_pkg::OFS_CONTROL, {7'h00, lj});
        conv(c, d);
        check("flag", 16'(mflag), 16'(e));
        check("ljust", 16'(ljo), 16'(lj));
        rd_chk("res_hi", awc_pkg::OFS_RESULT_HIGH, w[15:8]);
        rd_chk("res_lo", awc_pkg::OFS_RESULT_LOW, w[7:0]);
        rd_chk("ctl", awc_pkg::OFS_CONTROL, {6'h00, e, lj});
    endtask

    // free-running clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // hang guard
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fail_count++;
            close_out();
        end
    end

    // main sequence
    initial
    begin
        seed = 32'hd2443962;
        {rst_b, wr, rd, req, diff, addr, wdata, code} = '0;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        foreach (ofs[i])
            rd_chk("reset", ofs[i], awc_pkg::RST_BYTE);
        rd_chk("unmapped", 8'h12, awc_pkg::READ_UNMAPPED);
        wr_reg(awc_pkg::OFS_LOWER_LOW, 8'ha5);
        rd_chk("lower_lo", awc_pkg::OFS_LOWER_LOW, 8'ha5);
        // documented windows and their edges
        trial(16'h0040, 16'h0080, 10'h040, 1'b0, 1'b0);
        trial(16'h0040, 16'h0080, 10'h080, 1'b0, 1'b0);
        trial(16'h0080, 16'h0040, 10'h030, 1'b0, 1'b0);
        trial(16'h0080, 16'h0040, 10'h060, 1'b0, 1'b0);
        trial(16'h0040, 16'h0080, 10'h3ff, 1'b0, 1'b0);
        trial(16'h0040, 16'hffff, 10'h3fe, 1'b1, 1'b0);
        trial(16'h0040, 16'hffff, 10'h3ff, 1'b1, 1'b0);
        trial(16'hffff, 16'h0040, 10'h000, 1'b1, 1'b0);
        trial(16'h1000, 16'h2000, 10'h050, 1'b0, 1'b1);
        trial(16'h0040, 16'h0080, 10'h050, 1'b0, 1'b0);
        // result registers refuse writes, flag stays set
        wr_reg(awc_pkg::OFS_RESULT_LOW, 8'h3c);
        rd_chk("res_ro", awc_pkg::OFS_RESULT_LOW, 8'h50);
        conv(10'h000, 1'b0);
        check("sticky", 16'(mflag), 16'h0001);
        wr_reg(awc_pkg::OFS_CONTROL, 8'h00);
        repeat (2) @(posedge clk);
        #1;
        check("cleared", 16'(mflag), 16'h0000);
        // plain control bits store, software may set the flag
        wr_reg(awc_pkg::OFS_CONTROL, 8'hfe);
        rd_chk("ctl_store", awc_pkg::OFS_CONTROL, 8'hfe);
        repeat (150)
        begin
            r = $random(seed);
            trial(fmt(r[9:0], r[30], r[31]), fmt(r[19:10], r[30], r[31]),
                  r[29:20], r[30], r[31]);
        end
        close_out();
    end
endmodule // test_adc_window_comparator
